// File: inc/pls_pkg.sv
package pls_pkg;
    localparam int NPORT = 2;
    localparam int NLED  = 3;
    // register word indices; byte address = index * 4
    localparam logic [11:0] OFF_LEDCTL = 12'h018;
    localparam logic [11:0] OFF_PHYCTL = 12'h019;
    // second port sits one paddr[10] step above the first
    localparam logic [11:0] PORT_STRIDE = 12'h400;
    localparam int MODE_LO_POS   = 5;
    localparam int MODE_HI_POS   = 6;
    localparam int BLINK_LO_POS  = 6;
    localparam int ACT_SRC_POS   = 8;
    localparam logic [15:0] LEDCTL_RST = 16'h0000;
    localparam logic [15:0] PHYCTL_RST = 16'h0000;
    // blink half periods in ms for each blink_rate_field code
    localparam int BLINK_MS0 = 25;
    localparam int BLINK_MS1 = 50;
    localparam int BLINK_MS2 = 100;
    localparam int BLINK_MS3 = 200;
    localparam int CLK_MHZ   = 250;
    localparam int LINK_PULSES = 7;

    typedef enum logic [1:0] {
        PLS_MODE2 = 2'b00,
        PLS_MODE1 = 2'b01,
        PLS_MODE3 = 2'b10
    } pls_mode_t;

    typedef struct packed {
        logic link_good100;
        logic nlp;
        logic good_pkt10;
        logic link_loss;
        logic speed100;
        logic full_duplex;
        logic tx_act;
        logic rx_act;
        logic mii_col;
    } pls_stat_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } pls_apb_req_t;
endpackage

// File: rtl/pls_led_driver.sv
// How it works
// (RL1) each port drives link, speed and activity/collision/duplex indicators
// (RL2) mode select sits in port_phy_control bits 6:5
// (RL3) low mode bit loads from the port carrier sense strap
// (RL4) high mode bit changes only by register write
// (RL5) mode 1: link steady on link, third shows activity
// (RL6) mode 2: third indicator shows collision
// (RL7) mode 3: third indicator shows full duplex at either speed
// (RL8) modes 2 and 3: link on when good, blinks with activity
// (RL9) blink rate set by indicator_direct_control bits 7:6
// (RL10) activity source bit 8 clear: transmit or receive counts
// (RL11) activity source bit set: only receive counts
// (RL12) speed indicator on at 100 Mb/s, off at 10 Mb/s
// (RL13) 10 Mb/s link after seven pulses or one good packet
// (RL14) 100 Mb/s link follows signal detect, drops by link loss timer; the code takes link_good100 alone at 100 Mb/s, link_loss clears only link10 and nlp_cnt
// (RL15) 10 Mb/s half duplex collision comes from mii col
// (RL16) strap low gives active high output, strap high active low
// (RL17) straps captured once at reset release, held until next reset
//
// Our own choice: register access over APB.
module pls_led_driver #(
    parameter int BLINK_DIV = pls_pkg::CLK_MHZ * 1000
) (
    input  wire logic                                  i_clk,
    input  wire logic                                  i_sys_rst,
    input  wire pls_pkg::pls_apb_req_t                 i_apb,
    output logic [31:0]                                o_prdata,
    output logic                                       o_pready,
    output logic                                       o_pslverr,
    input  wire pls_pkg::pls_stat_t [pls_pkg::NPORT-1:0] i_stat,
    input  wire logic [pls_pkg::NPORT-1:0]             i_carrier_sense_strap,
    input  wire logic [pls_pkg::NPORT-1:0][pls_pkg::NLED-1:0] i_led_strap,
    output logic [pls_pkg::NPORT-1:0][pls_pkg::NLED-1:0] o_led
);
    import pls_pkg::*;

    typedef struct packed {
        logic [NPORT-1:0][15:0]      ledctl;
        logic [NPORT-1:0][15:0]      phyctl;
        logic [NPORT-1:0][NLED-1:0]  pol_low;
        logic                        strap_done;
        logic [NPORT-1:0][2:0]       nlp_cnt;
        logic [NPORT-1:0]            link10;
        logic [NPORT-1:0][31:0]      blink_cnt;
        logic [NPORT-1:0]            blink_ph;
        logic [NPORT-1:0][NLED-1:0]  led;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
    } pls_state_t;

    pls_state_t st_reg;
    pls_state_t st_next;

    function automatic logic [31:0] half_cycles(input logic [1:0] code);
        logic [31:0] ms;
        ms = 32'(BLINK_MS0);
        unique case (code)
            2'd0: ms = 32'(BLINK_MS0);
            2'd1: ms = 32'(BLINK_MS1);
            2'd2: ms = 32'(BLINK_MS2);
            2'd3: ms = 32'(BLINK_MS3);
        endcase
        return 32'(ms * 32'(BLINK_DIV));
    endfunction

    always_comb begin
        logic        hit;
        logic [0:0]  port;
        logic [11:0] idx;
        logic        link;
        logic        act;
        logic        col;
        logic [NLED-1:0] raw;
        pls_mode_t   mode;
        st_next = st_reg;
        hit = 1'b0;
        link = 1'b0;
        act = 1'b0;
        col = 1'b0;
        raw = '0;
        mode = PLS_MODE2;
        port = i_apb.paddr[10 +: 1];
        // paddr[10] picks the port, so only paddr[9:2] form the word index
        idx = {2'b00, i_apb.paddr[11:2]} & 12'h0ff;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;

        if (!st_reg.strap_done) begin
            st_next.strap_done = 1'b1;
            for (int p = 0; p < NPORT; p++) begin
                st_next.pol_low[p] = i_led_strap[p];                         // [RL16] [RL17]
                st_next.phyctl[p][MODE_LO_POS] = i_carrier_sense_strap[p];   // [RL3] [RL17]
            end
        end

        // apb slave: one wait state, answer in the access phase
        if (i_apb.psel && i_apb.penable && !st_reg.pready) begin
            st_next.pready = 1'b1;
            st_next.prdata = '0;
            if (idx == OFF_LEDCTL || idx == OFF_PHYCTL) begin
                hit = 1'b1;
            end
            st_next.pslverr = !hit || (i_apb.paddr[1:0] != 2'b00)
                              || (i_apb.paddr[11] != 1'b0);
            if (!st_next.pslverr) begin
                if (i_apb.pwrite) begin
                    if (idx == OFF_LEDCTL) begin
                        st_next.ledctl[port] = i_apb.pwdata[15:0];           // [RL9] [RL10]
                    end else begin
                        st_next.phyctl[port] = i_apb.pwdata[15:0];           // [RL2] [RL4]
                    end
                end else begin
                    st_next.prdata = (idx == OFF_LEDCTL)
                        ? {16'h0000, st_reg.ledctl[port]}
                        : {16'h0000, st_reg.phyctl[port]};
                end
            end
        end

        for (int p = 0; p < NPORT; p++) begin
            // 10 Mb/s link qualification
            if (i_stat[p].link_loss) begin
                st_next.nlp_cnt[p] = '0;
                st_next.link10[p] = 1'b0;
            end else if (i_stat[p].good_pkt10) begin
                st_next.link10[p] = 1'b1;                                    // [RL13]
            end else if (i_stat[p].nlp) begin
                if (st_reg.nlp_cnt[p] == 3'(LINK_PULSES - 1)) begin
                    st_next.link10[p] = 1'b1;                                // [RL13]
                end else begin
                    st_next.nlp_cnt[p] = st_reg.nlp_cnt[p] + 3'd1;
                end
            end
            link = i_stat[p].speed100 ? i_stat[p].link_good100               // [RL14]
                                      : st_reg.link10[p];
            act = st_reg.ledctl[p][ACT_SRC_POS] ? i_stat[p].rx_act           // [RL11]
                                                : (i_stat[p].rx_act || i_stat[p].tx_act); // [RL10]
            col = !i_stat[p].full_duplex && i_stat[p].mii_col;               // [RL15]

            // blink timer free runs while active
            if (!act) begin
                st_next.blink_cnt[p] = '0;
                st_next.blink_ph[p] = 1'b0;
            end else if (st_reg.blink_cnt[p] >=
                         half_cycles(st_reg.ledctl[p][BLINK_LO_POS +: 2]) - 32'd1) begin
                st_next.blink_cnt[p] = '0;
                st_next.blink_ph[p] = !st_reg.blink_ph[p];                   // [RL9]
            end else begin
                st_next.blink_cnt[p] = st_reg.blink_cnt[p] + 32'd1;
            end

            mode = pls_mode_t'(st_reg.phyctl[p][MODE_HI_POS:MODE_LO_POS]);
            if (st_reg.phyctl[p][MODE_LO_POS]) begin
                mode = PLS_MODE1;
            end
            raw[1] = i_stat[p].speed100;                                     // [RL12]
            unique case (mode)
                PLS_MODE1: begin
                    raw[0] = link;                                           // [RL5]
                    raw[2] = act;                                            // [RL5]
                end
                PLS_MODE2: begin
                    raw[0] = link && !(act && st_reg.blink_ph[p]);           // [RL8]
                    raw[2] = col;                                            // [RL6]
                end
                PLS_MODE3: begin
                    raw[0] = link && !(act && st_reg.blink_ph[p]);           // [RL8]
                    raw[2] = i_stat[p].full_duplex;                          // [RL7]
                end
                default: begin
                    raw[0] = link;
                    raw[2] = act;
                end
            endcase
            st_next.led[p] = raw ^ st_reg.pol_low[p];                        // [RL1] [RL16]
        end
        st_next.prdata = st_next.pready ? st_next.prdata : '0;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_reg <= '{ledctl: {NPORT{LEDCTL_RST}}, phyctl: {NPORT{PHYCTL_RST}},
                        default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_prdata  = st_reg.prdata;
    assign o_pready  = st_reg.pready;
    assign o_pslverr = st_reg.pslverr;
    assign o_led     = st_reg.led;
endmodule

// File: tb/pls_led_driver_checker.sv
module pls_led_driver_checker
    import pls_pkg::*;
#(
    parameter int BLINK_DIV = 4
) (
    input wire logic                            i_clk,
    input wire logic                            i_sys_rst,
    input wire pls_apb_req_t                    i_apb,
    input wire logic [31:0]                     o_prdata,
    input wire logic                            o_pready,
    input wire logic                            o_pslverr,
    input wire pls_stat_t [NPORT-1:0]           i_stat,
    input wire logic [NPORT-1:0]                i_carrier_sense_strap,
    input wire logic [NPORT-1:0][NLED-1:0]      i_led_strap,
    input wire logic [NPORT-1:0][NLED-1:0]      o_led
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]            up;
    logic [NPORT-1:0][1:0] md;
    logic [NPORT-1:0]      src;
    pls_stat_t [NPORT-1:0] sq;
    wire wr = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite && !o_pslverr;
    wire bad = i_apb.paddr[11] || (i_apb.paddr[9:0] != 10'h060 && i_apb.paddr[9:0] != 10'h064);
    // shadow of mode and source bits as the design holds them; the strap loads on
    // the first edge after reset, the same edge at which the design takes it
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            up <= 2'h0;
            md <= '0;
            src <= '0;
            sq <= '0;
        end else begin
            if (up != 2'h3)
                up <= up + 2'h1;
            if (up == 2'h0)
                for (int p = 0; p < NPORT; p++)
                    md[p] <= {1'b0, i_carrier_sense_strap[p]};
            if (wr && i_apb.paddr[9:0] == 10'h064)
                md[i_apb.paddr[10]] <= i_apb.pwdata[6:5];
            if (wr && i_apb.paddr[9:0] == 10'h060)
                src[i_apb.paddr[10]] <= i_apb.pwdata[8];
            sq <= i_stat;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        chk_speed_ind: assert property (up == 2'h3 |->
            o_led[p][1] == (sq[p].speed100 ^ i_led_strap[p][1])) else $error("speed wrong");
        chk_act_mode1: assert property (up == 2'h3 && md[p][0] |->
            o_led[p][2] == ((sq[p].rx_act | (sq[p].tx_act & !src[p])) ^ i_led_strap[p][2]))
            else $error("activity wrong");
        chk_col_mode2: assert property (up == 2'h3 && md[p] == 2'b00 |->
            o_led[p][2] == ((sq[p].mii_col & !sq[p].full_duplex) ^ i_led_strap[p][2]))
            else $error("collision wrong");
        chk_dup_mode3: assert property (up == 2'h3 && md[p] == 2'b10 |->
            o_led[p][2] == (sq[p].full_duplex ^ i_led_strap[p][2])) else $error("duplex wrong");
        chk_link_fast: assert property (up == 2'h3 && md[p][0] && sq[p].speed100 |->
            o_led[p][0] == (sq[p].link_good100 ^ i_led_strap[p][0])) else $error("link wrong");
    end
    chk_ready_next: assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready)
        else $error("no answer");
    chk_ready_once: assert property (o_pready |=> !o_pready) else $error("pready too long");
    chk_err_addr: assert property (o_pready |-> o_pslverr == bad) else $error("pslverr wrong");
    chk_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("prdata not 0");
    cover property (o_pready && o_pslverr);
    cover property (md[0] == 2'b10 && sq[0].full_duplex);
    cover property (o_pready && i_apb.pwrite);
endmodule

bind pls_led_driver pls_led_driver_checker #(.BLINK_DIV(BLINK_DIV)) i_chk (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_stat(i_stat), .i_carrier_sense_strap(i_carrier_sense_strap),
    .i_led_strap(i_led_strap), .o_led(o_led));

// File: tb/pls_led_partner.sv
module pls_led_partner #(
    parameter logic [1:0]      CS = 2'b01,
    parameter logic [1:0][2:0] LS = 6'b111_010
) (
    input  wire logic [1:0][2:0] i_led,
    output logic [1:0]           o_cs_strap,
    output logic [1:0][2:0]      o_led_strap,
    output logic [1:0][2:0]      o_lit
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_cs_strap = CS;
    assign o_led_strap = LS;
    // a pin pulled high is an active low driver, so it lights when low
    assign o_lit = i_led ^ LS;
endmodule

// File: tb/tb_pls_led_driver.sv
module tb_pls_led_driver;
    timeunit 1ns;
    timeprecision 1ps;
    import pls_pkg::*;
    logic            clk = 0, rst = 1, e;
    pls_apb_req_t    req = '0;
    pls_stat_t [1:0] st = '0;
    logic [31:0]     prd, q;
    logic            rdy, err;
    logic [1:0]      cs;
    logic [1:0][2:0] ls, led, lit;
    int              error_cnt = 0, samples_checked = 0, n, h;
    always #2 clk = ~clk;
    pls_led_driver #(.BLINK_DIV(4)) i_dut (.i_clk(clk), .i_sys_rst(rst), .i_apb(req),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_stat(st),
        .i_carrier_sense_strap(cs), .i_led_strap(ls), .o_led(led));
    pls_led_partner i_led (.i_led(led), .o_cs_strap(cs), .o_led_strap(ls), .o_lit(lit));
    task give_verdict;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, x);
        samples_checked++;
        if (s !== x) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, x, s);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 9);
        if (rdy !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        q = prd;
        e = err;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task put(input logic [8:0] v);
        @(posedge clk);
        st[0] <= v;
    endtask
    task lit_is(input logic [2:0] x);
        repeat (2) @(posedge clk);
        chk("lit_a", lit[0], x);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, 12'h064, 0);
        chk("phyctl_a", q, 32'h20);
        bus(0, 12'h464, 0);
        chk("phyctl_b", q, 32'h0);
        bus(0, 12'h068, 0);
        chk("unmapped", e, 1);
        chk("raw_b", led[1], 3'b111);
        lit_is(3'b000);
        put(9'h112);
        lit_is(3'b111);
        put(9'h114);
        lit_is(3'b111);
        bus(1, 12'h060, 32'h100);
        lit_is(3'b011);
        bus(1, 12'h064, 32'h40);
        put(9'h118);
        lit_is(3'b111);
        bus(0, 12'h064, 0);
        chk("mode_hi", q, 32'h40);
        bus(1, 12'h064, 0);
        put(9'h111);
        lit_is(3'b111);
        $display("mode tests done");
        put(9'h112);
        for (int c = 0; c < 4; c++) begin
            bus(1, 12'h060, c << 6);
            h = (BLINK_MS0 << c) * 4;
            repeat (2 * h) @(posedge clk);
            n = 0;
            repeat (4 * h) begin
                @(posedge clk);
                n += (lit[0][0] === 1'b0);
            end
            chk("blink_off", n, 2 * h);
        end
        $display("blink tests done");
        put(9'h020);
        repeat (6) begin
            put(9'h080);
            put(9'h000);
        end
        lit_is(3'b000);
        put(9'h080);
        put(9'h000);
        lit_is(3'b001);
        put(9'h001);
        lit_is(3'b101);
        put(9'h009);
        lit_is(3'b001);
        put(9'h020);
        put(9'h000);
        lit_is(3'b000);
        put(9'h040);
        put(9'h000);
        lit_is(3'b001);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, 12'h064, 0);
        chk("phyctl_rst", q, 32'h20);
        $display("link tests done");
        give_verdict();
    end
endmodule
